/* File: fpcp_port.sv */
// fpcp_port.sv: parallel programming port of an on-chip flash array
// assumes pins are already synchronous to ref_clk; power-on via rst_n
`timescale 1ns/1ns
`default_nettype none
`include "fpcp_cfg.svh"
module fpcp_port
  import fpcp_pkg::*;
#(
  parameter int unsigned ADDR_W     = 17,
  parameter int unsigned DEPTH      = 1024,
  parameter int unsigned PROG_CYC   =
    (`FPCP_PROG_TIME_NS) / (`FPCP_CLK_PERIOD_NS),
  parameter int unsigned ERASE_CYC  =
    (`FPCP_ERASE_TIME_NS) / (`FPCP_CLK_PERIOD_NS),
  parameter logic [7:0]  MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0]  DEV_CODE   = 8'hA5  // arbitrary value
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // supply level and strobes
  input  wire logic              program_supply_high,
  input  wire logic              chip_sel_n,
  input  wire logic              out_en_n,
  input  wire logic              write_n,
  // address and data pins
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        data_in,
  output logic      [7:0]        data_out,
  output logic                   data_oe,
  // status
  output logic                   busy,
  output logic                   standby
);
  localparam int unsigned TW = 20;
  localparam int unsigned IW = $clog2(DEPTH);

  logic [7:0]        mem [DEPTH];
  fpcp_state_type    st_q, st_d;
  logic [7:0]        cmd_q, cmd_d;
  logic [ADDR_W-1:0] alat_q, alat_d;   // address taken at strobe fall
  logic [ADDR_W-1:0] padr_q, padr_d;   // program / verify address
  logic [7:0]        pdat_q, pdat_d;
  logic              we_q;
  logic [7:0]        dout_q, dout_d;
  logic              oe_q, oe_d;
  logic              sb_q;
  logic              busy_q, busy_d;
  logic [TW-1:0]     pcnt_q, pcnt_d;   // helper: cycles spent programming
  logic              fall, rise, wr_ok;
  logic              t_start, t_busy, t_done;
  logic [TW-1:0]     t_load;
  logic              mem_wr, mem_clr;

  // write strobe edges; input accepted only in write state
  assign fall  = we_q & ~write_n;
  assign rise  = ~we_q & write_n;
  assign wr_ok = program_supply_high & ~chip_sel_n & out_en_n;

  // command sequencer
  always_comb begin
    st_d    = st_q;
    cmd_d   = cmd_q;
    alat_d  = alat_q;
    padr_d  = padr_q;
    pdat_d  = pdat_q;
    t_start = 1'b0;
    t_load  = TW'(PROG_CYC);
    if (!program_supply_high) begin
      cmd_d = `FPCP_CMD_READ;
      if (st_q != FPCP_BUSY) st_d = FPCP_IDLE;
    end
    if (fall && wr_ok) alat_d = addr;
    case (st_q)
      FPCP_IDLE: begin
        if (rise && wr_ok) begin
          cmd_d = data_in;
          if (data_in == `FPCP_CMD_EVERIFY) padr_d = alat_q;
          if (data_in != `FPCP_CMD_READ) st_d = FPCP_SECOND;
        end
      end
      FPCP_SECOND: begin
        if (rise && wr_ok) begin
          if (data_in == `FPCP_CMD_RESET &&
              (cmd_q == `FPCP_CMD_PROGRAM || cmd_q == `FPCP_CMD_ERASE)) begin
            st_d = FPCP_CANCEL;
          end else if (cmd_q == `FPCP_CMD_PROGRAM) begin
            padr_d  = alat_q;
            pdat_d  = data_in;
            t_start = 1'b1;
            st_d    = FPCP_BUSY;
          end else if (cmd_q == `FPCP_CMD_ERASE &&
                       data_in == `FPCP_CMD_ERASE) begin
            t_load  = TW'(ERASE_CYC);
            t_start = 1'b1;
            st_d    = FPCP_BUSY;
          end else begin
            cmd_d = data_in; // unknown sequence: treat as new command
            st_d  = (data_in == `FPCP_CMD_READ) ? FPCP_IDLE : FPCP_SECOND;
          end
        end else if (fall && wr_ok) begin
          st_d = st_q;
        end
        // verify and ident end when their read cycle closes; a read
        // may hold the enable low for many clocks
        if (oe_q && !oe_d &&
            cmd_q != `FPCP_CMD_PROGRAM && cmd_q != `FPCP_CMD_ERASE) begin
          st_d = FPCP_IDLE;
        end
      end
      FPCP_CANCEL: begin
        if (rise && wr_ok) begin
          cmd_d = `FPCP_CMD_READ;
          st_d  = FPCP_IDLE;
        end
      end
      FPCP_BUSY: begin
        if (t_done) begin
          cmd_d = `FPCP_CMD_READ;
          st_d  = FPCP_IDLE;
        end
      end
      default: st_d = FPCP_IDLE;
    endcase
  end

  // array writes: one byte for program, whole array for erase
  assign mem_wr  = t_done && cmd_q == `FPCP_CMD_PROGRAM;
  assign mem_clr = t_done && cmd_q == `FPCP_CMD_ERASE;

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (mem_clr) mem[i] <= `FPCP_ERASED_BYTE;
    end
    if (mem_wr) mem[padr_q[IW-1:0]] <= pdat_q;
  end

  // read data path and pin drive
  always_comb begin
    oe_d   = ~chip_sel_n & ~out_en_n & write_n;
    dout_d = mem[addr[IW-1:0]];
    if (program_supply_high && st_q == FPCP_SECOND) begin
      case (cmd_q)
        `FPCP_CMD_PVERIFY: dout_d = mem[padr_q[IW-1:0]];
        `FPCP_CMD_EVERIFY: dout_d = mem[padr_q[IW-1:0]];
        `FPCP_CMD_IDENT: begin
          if (addr == `FPCP_IDENT_MAKER)       dout_d = MAKER_CODE;
          else if (addr == `FPCP_IDENT_DEVICE) dout_d = DEV_CODE;
          else                                 dout_d = 8'h00;
        end
        default: dout_d = mem[addr[IW-1:0]];
      endcase
    end
  end

  // busy follows the next state so the pin comes from a flop
  assign busy_d = (st_d == FPCP_BUSY);

  // check helper: cycles spent in a timed program
  always_comb begin
    pcnt_d = '0;
    if (st_q == FPCP_BUSY && cmd_q == `FPCP_CMD_PROGRAM) begin
      pcnt_d = pcnt_q + 1'b1;
    end
  end

  // state registers; latch resets to read code
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      pcnt_q <= '0;
      st_q   <= FPCP_IDLE;
      cmd_q  <= `FPCP_CMD_READ;
      alat_q <= '0;
      padr_q <= '0;
      pdat_q <= 8'h00;
      we_q   <= 1'b1;
      dout_q <= 8'h00;
      oe_q   <= 1'b0;
      sb_q   <= 1'b1;
    end else begin
      busy_q <= busy_d;
      pcnt_q <= pcnt_d;
      st_q   <= st_d;
      cmd_q  <= cmd_d;
      alat_q <= alat_d;
      padr_q <= padr_d;
      pdat_q <= pdat_d;
      we_q   <= write_n;
      dout_q <= dout_d;
      oe_q   <= oe_d;
      sb_q   <= chip_sel_n;
    end
  end

  fpcp_op_timer #(.WIDTH(TW)) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (t_start),
    .load    (t_load),
    .busy    (t_busy),
    .done    (t_done)
  );

  assign data_out = dout_q;
  assign data_oe  = oe_q;
  assign busy     = busy_q;
  assign standby  = sb_q;

  // checks
  chk_float_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(out_en_n) || $past(chip_sel_n) |-> !data_oe)
    else $error("data driven while disabled");
  chk_drive_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) && !$past(out_en_n) && !$past(chip_sel_n) &&
    $past(write_n) |-> data_oe)
    else $error("data not driven in read state");
  chk_prog_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pcnt_q <= TW'(PROG_CYC + 1))
    else $error("program exceeded its time");
  chk_low_ignore: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !program_supply_high |-> !t_start)
    else $error("operation started with supply low");
  chk_cancel_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_q == FPCP_CANCEL && rise && wr_ok |=> cmd_q == 8'h00 && !t_busy)
    else $error("cancel did not return to read");
  chk_erase_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    t_start && t_load == TW'(ERASE_CYC) |-> cmd_q == `FPCP_CMD_ERASE)
    else $error("erase started without erase command");
  chk_one_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mem_wr |-> !mem_clr && $past(st_q) == FPCP_BUSY)
    else $error("program write outside timed op");
  chk_start_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
    t_start |-> rise && wr_ok && st_q == FPCP_SECOND)
    else $error("operation started off strobe rise");
  cov_program: cover property (@(posedge ref_clk) mem_wr);
  cov_erase: cover property (@(posedge ref_clk) mem_clr);
  cov_cancel: cover property (@(posedge ref_clk) st_q == FPCP_CANCEL);
endmodule
`default_nettype wire

/* File: fpcp_cfg.svh */
// fpcp_cfg.svh: constants of the parallel flash command port
// assumes inclusion by the port module by bare name
`ifndef FPCP_CFG_SVH
`define FPCP_CFG_SVH
`define FPCP_CMD_READ      8'h00
`define FPCP_CMD_PROGRAM   8'h40
`define FPCP_CMD_PVERIFY   8'hC0
`define FPCP_CMD_ERASE     8'h20
`define FPCP_CMD_EVERIFY   8'hA0
`define FPCP_CMD_RESET     8'hFF
`define FPCP_CMD_IDENT     8'h90
`define FPCP_IDENT_MAKER   17'h00000
`define FPCP_IDENT_DEVICE  17'h00001
`define FPCP_CLK_MHZ       100
`define FPCP_PROG_TIME_NS  10000
`define FPCP_ERASE_TIME_NS 9500000
`define FPCP_CLK_PERIOD_NS 10
`define FPCP_ERASED_BYTE   8'hFF
`endif

/* File: fpcp_pkg.sv */
// fpcp_pkg.sv: types of the parallel flash command port
// assumes fpcp_cfg.svh holds the constants
package fpcp_pkg;
  // write-cycle sequencer states
  typedef enum logic [4:0] {
    FPCP_IDLE   = 5'b00001, // waiting for a first cycle
    FPCP_SECOND = 5'b00010, // command latched, waiting second cycle
    FPCP_CANCEL = 5'b00100, // 0xFF seen in second cycle
    FPCP_BUSY   = 5'b01000, // timed program or erase running
    FPCP_RSV    = 5'b10000
  } fpcp_state_type;
endpackage

/* File: fpcp_op_timer.sv */
// fpcp_op_timer.sv: down-counter timing program and erase operations
// assumes start is a one-cycle pulse in the ref_clk domain
`timescale 1ns/1ns
`default_nettype none
module fpcp_op_timer #(
  parameter int unsigned WIDTH = 20
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] load,
  // status
  output logic                  busy,
  output logic                  done
);
  logic [WIDTH-1:0] cnt_q, cnt_d;
  logic             done_q, done_d;

  // count down, pulse done on reaching zero
  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = load;
    end else if (cnt_q != '0) begin
      cnt_d  = cnt_q - 1'b1;
      done_d = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign busy = (cnt_q != '0);
  assign done = done_q;
endmodule
`default_nettype wire

/* File: fpcp_prog_model.sv */
// fpcp_prog_model.sv: behavioural parallel programmer
// assumes the bench calls its tasks; pins move 1 ns after ref_clk
`timescale 1ns/1ns
`default_nettype none
module fpcp_prog_model (
  // clock
  input  wire logic       ref_clk,
  // strobes, address and data towards the port
  output logic            chip_sel_n,
  output logic            out_en_n,
  output logic            write_n,
  output logic [16:0]     addr,
  output logic [7:0]      data_in,
  // answer from the port
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  input  wire logic       busy
);
  // idle: deselected, all strobes high
  initial begin
    chip_sel_n = 1'b1;
    out_en_n = 1'b1;
    write_n = 1'b1;
    addr = 17'h00000;
    data_in = 8'h00;
  end
  // strobe low over two edges; lines inverted once released
  task automatic wcyc(input logic [16:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    chip_sel_n = 1'b0;
    write_n = 1'b0;
    addr = a;
    data_in = d;
    repeat (2) @(posedge ref_clk);
    #1 write_n = 1'b1;
    @(posedge ref_clk) #1;
    addr = ~a;
    data_in = ~d;
  endtask
  // read: answer is registered, so sample two edges later
  task automatic rcyc(input logic [16:0] a, output logic [7:0] d,
                      output logic oe);
    @(posedge ref_clk) #1;
    chip_sel_n = 1'b0;
    out_en_n = 1'b0;
    addr = a;
    repeat (2) @(posedge ref_clk);
    #1 d = data_out;
    oe = data_oe;
    out_en_n = 1'b1;
    addr = ~a;
  endtask
  // bounded wait for a timed operation; n counts busy cycles
  task automatic waitb(output int n);
    n = 0;
    repeat (4) if (busy !== 1'b1) @(posedge ref_clk) #1;
    while (busy === 1'b1 && n < 5000) begin
      @(posedge ref_clk) #1;
      n++;
    end
  endtask
  // program then verify, at most four tries, stopping once the byte reads back
  task automatic prog(input logic [16:0] a, input logic [7:0] d,
                      output int n);
    logic [7:0] v;
    logic       oe;
    v = ~d;
    for (int i = 0; i < 4 && v !== d; i++) begin
      wcyc(17'h00000, 8'h40);
      wcyc(a, d);
      waitb(n);
      wcyc(17'h00000, 8'hC0);
      rcyc(~a, v, oe);
    end
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// testbench.sv: self-checking bench for the flash command port
// assumes fpcp_prog_model drives the pins; timers shortened
`timescale 1ns/1ns
`default_nettype none
module testbench import fpcp_pkg::*;;
  localparam int PG = 20;
  localparam int ER = 40;
  localparam logic [7:0] MK = 8'h3C; // arbitrary value
  localparam logic [7:0] DV = 8'hC3; // arbitrary value
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sup_hi = 1'b1;
  logic        cs_n, oe_n, we_n, doe, busy, stby, oe;
  logic [16:0] addr;
  logic [7:0]  din, dout, v;
  int          n, bad, tries, k;
  int          miscompares = 0;
  int          samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  fpcp_port #(.DEPTH(16), .PROG_CYC(PG), .ERASE_CYC(ER),
    .MAKER_CODE(MK), .DEV_CODE(DV)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .program_supply_high(sup_hi),
    .chip_sel_n(cs_n), .out_en_n(oe_n), .write_n(we_n),
    .addr(addr), .data_in(din), .data_out(dout), .data_oe(doe),
    .busy(busy), .standby(stby));
  fpcp_prog_model pm (
    .ref_clk(ref_clk), .chip_sel_n(cs_n), .out_en_n(oe_n),
    .write_n(we_n), .addr(addr), .data_in(din), .data_out(dout),
    .data_oe(doe), .busy(busy));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic rng(string nm, int hi, int g);
    samples_checked++;
    if (g < 1 || g > hi) begin
      miscompares++;
      $display("Error %s expected 1..%0d seen %0d", nm, hi, g);
    end
  endtask
  task automatic rd(logic [16:0] a, logic [7:0] e);
    pm.rcyc(a, v, oe);
    chk("read data", e, v);
    chk("data enable", 1, oe);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_idle();
    chk("busy", 0, busy);
    chk("standby", 1, stby);
    chk("idle enable", 0, doe);
  endtask
  task automatic t_prog();
    pm.prog(17'h5, 8'h77, n);
    rng("program time", PG + 2, n);
    pm.prog(17'h6, 8'hA5, n);
    pm.prog(17'h7, 8'h5A, n);
    pm.wcyc(17'h0, 8'hC0);
    rd(17'h1FFF0, 8'h5A);
    pm.wcyc(17'h0, 8'h00);
    rd(17'h6, 8'hA5);
    rd(17'h7, 8'h5A);
    rd(17'h5, 8'h77);
    repeat (2) @(posedge ref_clk);
    #1 chk("float enable", 0, doe);
  endtask
  // supply low: a full program sequence must change nothing
  task automatic t_ro();
    @(posedge ref_clk) #1 sup_hi = 1'b0;
    pm.wcyc(17'h0, 8'h40);
    pm.wcyc(17'h5, 8'h11);
    pm.waitb(n);
    chk("busy cycles", 0, n);
    rd(17'h5, 8'h77);
    @(posedge ref_clk) #1 sup_hi = 1'b1;
  endtask
  task automatic t_ident();
    for (int i = 0; i < 2; i++) begin
      pm.wcyc(17'h0, 8'h90);
      rd(17'(i), (i == 1) ? DV : MK);
    end
  endtask
  // mid-run reset must bring the latch back to read
  task automatic t_reset();
    @(posedge ref_clk) #1 rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    rd(17'h7, 8'h5A);
  endtask
  task automatic t_cancel();
    pm.wcyc(17'h0, 8'h40);
    pm.wcyc(17'h5, 8'hFF);
    pm.wcyc(17'h0, 8'hFF);
    pm.waitb(n);
    chk("busy cycles", 0, n);
    rd(17'h5, 8'h77);
    pm.wcyc(17'h0, 8'h20);
    pm.wcyc(17'h0, 8'hFF);
    pm.wcyc(17'h0, 8'hFF);
    rd(17'h6, 8'hA5);
  endtask
  // zero all, erase, verify all; repeat erase on a miss
  task automatic t_erase();
    for (int a = 0; a < 16; a++) pm.prog(17'(a), 8'h00, k);
    bad = 1;
    for (tries = 0; tries < 3 && bad != 0; tries++) begin
      pm.wcyc(17'h0, 8'h20);
      pm.wcyc(17'h0, 8'h20);
      pm.waitb(n);
      bad = 0;
      for (int a = 0; a < 16; a++) begin
        pm.wcyc(17'(a), 8'hA0);
        pm.rcyc(17'h1FFFF, v, oe);
        if (v !== 8'hFF) bad++;
      end
    end
    chk("erase rounds", 1, tries);
    rng("erase time", ER + 2, n);
    pm.prog(17'h3, 8'h12, k);
    pm.wcyc(17'h3, 8'hA0);
    rd(17'h1FFFF, 8'h12);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_idle();
    t_prog();
    t_ro();
    t_ident();
    t_reset();
    t_cancel();
    t_erase();
    conclude();
  end
  // watchdog: the run needs about a thousand cycles only
  initial begin
    #400000;
    miscompares++;
    $display("Error watchdog expected finish seen hang");
    conclude();
  end
endmodule
`default_nettype wire
